// file: core/sfr_cfg.svh
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
// Command codes
`define SFR_NORMAL_READ_CMD   8'h03
`define SFR_FAST_READ_CMD     8'h0B
`define SFR_DUAL_IO_READ_CMD  8'hBB
`define SFR_QUAD_IO_READ_CMD  8'hEB
`define SFR_UNIQUE_ID_CMD     8'h4B
`define SFR_INFO_ROW_CMD      8'h68
// Register word indices
`define SFR_CTRL_IDX          4'h0
`define SFR_DUMMY_IDX         4'h1
`define SFR_STATUS_IDX        4'h2
`define SFR_ADDR_IDX          4'h3
`define SFR_MEM_PTR_IDX       4'h4
`define SFR_MEM_DATA_IDX      4'h5
// Control field positions
`define SFR_CTRL_QUAD_MODE    0
`define SFR_CTRL_QUAD_EN      1
`define SFR_CTRL_DTR          2
`define SFR_CTRL_RST_PIN      3
`define SFR_CTRL_WIP          4
// Dummy field reset values
`define SFR_FAST_DUMMY_RST    4'h8
`define SFR_QUAD_DUMMY_RST    4'h6
`define SFR_DUAL_DUMMY_RST    4'h4
// Phase lengths in bits, mode length in clocks, continuous-read nibble, array size in words
`define SFR_CMD_BITS          5'h08
`define SFR_ADDR_BITS         5'h18
`define SFR_MODE_BITS         5'h08
`define SFR_MODE_CLKS         4'h4
`define SFR_CONT_NIBBLE       4'hA
`define SFR_MEM_WORDS         256
`endif

// file: core/sfr_pkg.sv
package sfr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_MODE,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } sfr_state_t;
endpackage

// file: core/sfr_top.sv
// Overview of operation
// - Accept normal read code 03h, host below 80MHz
// - Shift 24 address bits, decode only 22..0
// - Ignore SI after normal read address
// - Output bytes MSB first from given address
// - Increment address per byte, wrap to zero
// - Chip select high ends read, release outputs
// - Discard reads while write in progress
// - Fast read: opcode, address, dummy on SI
// - Fast read output changes on falling edges
// - Quad mode: 2 opcode, 6 address clocks, 6 dummy
// - Quad mode data four bits per clock
// - Quad framing also for EBh, 4Bh, 68h
// - Pause low while SCK low freezes sequence
// - Pause high while SCK low resumes
// - Paused: outputs released, SI ignored
// - Pause disabled by DTR, quad enable, reset pin
// - Dual I/O address two bits per edge, 4 dummy
// - Dual output MSB on IO1, next IO0
// - Mode byte four clocks, upper nibble only
// - Nibble 1010 enters continuous read, else leaves
// - Read end keeps single or quad mode
// - Mode clocks count within dummy cycles
`timescale 1ns/10ps
`include "sfr_cfg.svh"
module sfr_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        pause_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [6:0]  sync1;
  logic [6:0]  sync2;
  logic        sck_d;
  logic        sck_s;
  logic        cs_n_s;
  logic        pause_n_s;
  logic [3:0]  io_s;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_d;
  logic        cs_start;

  sfr_pkg::sfr_state_t state_reg;
  logic [7:0]  op_reg;
  logic [23:0] sh_reg;
  logic [4:0]  cnt_reg;
  logic [3:0]  dcnt_reg;
  logic [22:0] addr_reg;
  logic [2:0]  wid_reg;
  logic [7:0]  obyte_reg;
  logic [3:0]  pos_reg;
  logic        cont_reg;
  logic        paused_reg;
  logic [3:0]  oe_hold_reg;

  logic        quad_mode_reg;
  logic        quad_en_reg;
  logic        dtr_reg;
  logic        rst_pin_reg;
  logic        wip_reg;
  logic [3:0]  fast_dummy_reg;
  logic [3:0]  quad_dummy_reg;
  logic [3:0]  dual_dummy_reg;
  logic [7:0]  mem_ptr_reg;
  logic [7:0]  mem [0:`SFR_MEM_WORDS-1];

  logic [23:0] sh_next;
  logic [4:0]  cnt_next;
  logic [2:0]  in_w;
  logic [7:0]  cur_byte;
  logic        pause_ok;
  logic        run;
  logic        bus_acc;

  // Reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pins cross into clk; third sck copy only for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 7'h06;
      sync2 <= 7'h06;
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sync1 <= {io_in, pause_n, cs_n, sck};
      sync2 <= sync1;
      sck_d <= sync2[0];
      cs_d  <= sync2[1];
    end
  end
  assign sck_s     = sync2[0];
  assign cs_n_s    = sync2[1];
  assign pause_n_s = sync2[2];
  assign io_s      = sync2[6:3];
  assign sck_rise  = sck_s & ~sck_d;
  assign sck_fall  = ~sck_s & sck_d;
  assign cs_start  = cs_d & ~cs_n_s;

  // Pause handling
  assign pause_ok = ~dtr_reg & ~quad_en_reg & ~rst_pin_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      paused_reg <= 1'b0;
    end else if (cs_n_s || !pause_ok) begin
      paused_reg <= 1'b0;
    end else if (!sck_s && !pause_n_s && state_reg != sfr_pkg::ST_IDLE) begin
      paused_reg <= 1'b1;
    end else if (!sck_s && pause_n_s) begin
      paused_reg <= 1'b0;
    end
  end
  // Edges seen while paused do nothing
  assign run = ~paused_reg & ~cs_n_s;

  // Input width of the current phase
  always_comb begin
    in_w = 3'h1;
    unique case (state_reg)
      sfr_pkg::ST_CMD:  in_w = quad_mode_reg ? 3'h4 : 3'h1;
      sfr_pkg::ST_ADDR: in_w = wid_reg;
      sfr_pkg::ST_MODE: in_w = 3'h2;
      default:          in_w = 3'h1;
    endcase
  end

  always_comb begin
    sh_next  = {sh_reg[22:0], io_s[0]};
    cnt_next = cnt_reg + 5'h01;
    if (in_w == 3'h4) begin
      sh_next  = {sh_reg[19:0], io_s};
      cnt_next = cnt_reg + 5'h04;
    end else if (in_w == 3'h2) begin
      sh_next  = {sh_reg[21:0], io_s[1:0]};
      cnt_next = cnt_reg + 5'h02;
    end
  end

  // Command sequencer on rising link edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sfr_pkg::ST_IDLE;
      op_reg    <= 8'h00;
      sh_reg    <= 24'h000000;
      cnt_reg   <= 5'h00;
      dcnt_reg  <= 4'h0;
      wid_reg   <= 3'h1;
      cont_reg  <= 1'b0;
    end else if (cs_n_s) begin
      state_reg <= sfr_pkg::ST_IDLE;
    end else if (cs_start) begin
      sh_reg  <= 24'h000000;
      cnt_reg <= 5'h00;
      if (cont_reg && !wip_reg) begin
        state_reg <= sfr_pkg::ST_ADDR;
        op_reg    <= `SFR_DUAL_IO_READ_CMD;
        wid_reg   <= 3'h2;
      end else begin
        state_reg <= sfr_pkg::ST_CMD;
      end
    end else if (run && sck_rise) begin
      unique case (state_reg)
        sfr_pkg::ST_CMD: begin
          sh_reg  <= sh_next;
          cnt_reg <= cnt_next;
          if (cnt_next == `SFR_CMD_BITS) begin
            op_reg  <= sh_next[7:0];
            cnt_reg <= 5'h00;
            if (wip_reg) begin
              state_reg <= sfr_pkg::ST_IGNORE;
            end else begin
              state_reg <= sfr_pkg::ST_ADDR;
              unique case (sh_next[7:0])
                `SFR_NORMAL_READ_CMD: begin
                  wid_reg <= 3'h1;
                  if (quad_mode_reg) state_reg <= sfr_pkg::ST_IGNORE;
                end
                `SFR_FAST_READ_CMD,
                `SFR_UNIQUE_ID_CMD,
                `SFR_INFO_ROW_CMD: begin
                  wid_reg <= quad_mode_reg ? 3'h4 : 3'h1;
                end
                `SFR_QUAD_IO_READ_CMD: begin
                  wid_reg <= 3'h4;
                end
                `SFR_DUAL_IO_READ_CMD: begin
                  wid_reg <= 3'h2;
                  if (quad_mode_reg) state_reg <= sfr_pkg::ST_IGNORE;
                end
                default: begin
                  state_reg <= sfr_pkg::ST_IGNORE;
                end
              endcase
            end
          end
        end
        sfr_pkg::ST_ADDR: begin
          sh_reg  <= sh_next;
          cnt_reg <= cnt_next;
          if (cnt_next == `SFR_ADDR_BITS) begin
            cnt_reg <= 5'h00;
            if (op_reg == `SFR_DUAL_IO_READ_CMD) begin
              state_reg <= sfr_pkg::ST_MODE;
              dcnt_reg  <= dual_dummy_reg - `SFR_MODE_CLKS;
            end else if (op_reg == `SFR_NORMAL_READ_CMD) begin
              state_reg <= sfr_pkg::ST_DATA;
            end else begin
              state_reg <= sfr_pkg::ST_DUMMY;
              if (op_reg == `SFR_QUAD_IO_READ_CMD || quad_mode_reg) begin
                dcnt_reg <= quad_dummy_reg;
              end else begin
                dcnt_reg <= fast_dummy_reg;
              end
            end
          end
        end
        sfr_pkg::ST_MODE: begin
          cnt_reg <= cnt_next;
          if (cnt_next == `SFR_MODE_BITS) begin
            // Low nibble is never looked at
            cont_reg  <= (sh_next[7:4] == `SFR_CONT_NIBBLE);
            state_reg <= (dcnt_reg == 4'h0) ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
          end
          sh_reg[7:0] <= sh_next[7:0];
        end
        sfr_pkg::ST_DUMMY: begin
          if (dcnt_reg <= 4'h1) begin
            state_reg <= sfr_pkg::ST_DATA;
          end
          dcnt_reg <= dcnt_reg - 4'h1;
        end
        default: begin
        end
      endcase
    end else if (run && state_reg == sfr_pkg::ST_DUMMY && dcnt_reg == 4'h0) begin
      state_reg <= sfr_pkg::ST_DATA;
    end
  end

  // Data width follows the opcode and the current mode
  assign cur_byte = (pos_reg == 4'h0) ? mem[addr_reg[7:0]] : obyte_reg;

  // Output shifter on falling link edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg  <= 23'h000000;
      obyte_reg <= 8'h00;
      pos_reg   <= 4'h0;
      io_out      <= 4'h0;
      io_oe       <= 4'h0;
      oe_hold_reg <= 4'h0;
    end else if (cs_n_s || paused_reg) begin
      io_oe <= 4'h0;
      if (cs_n_s) begin
        pos_reg     <= 4'h0;
        oe_hold_reg <= 4'h0;
      end else if (io_oe != 4'h0) begin
        // Kept so the current bit returns on resume
        oe_hold_reg <= io_oe;
      end
    end else if (state_reg == sfr_pkg::ST_ADDR && run && sck_rise && cnt_next == `SFR_ADDR_BITS) begin
      addr_reg <= sh_next[22:0];
      pos_reg  <= 4'h0;
    end else if (state_reg == sfr_pkg::ST_DATA && run && sck_fall) begin
      oe_hold_reg <= 4'h0;
      if (op_reg == `SFR_DUAL_IO_READ_CMD) begin
        io_out    <= {2'h0, cur_byte[7:6]};
        io_oe     <= 4'h3;
        obyte_reg <= {cur_byte[5:0], 2'h0};
        pos_reg   <= pos_reg + 4'h2;
      end else if (op_reg == `SFR_QUAD_IO_READ_CMD || quad_mode_reg) begin
        io_out    <= cur_byte[7:4];
        io_oe     <= 4'hF;
        obyte_reg <= {cur_byte[3:0], 4'h0};
        pos_reg   <= pos_reg + 4'h4;
      end else begin
        io_out    <= {2'h0, cur_byte[7], 1'b0};
        io_oe     <= 4'h2;
        obyte_reg <= {cur_byte[6:0], 1'b0};
        pos_reg   <= pos_reg + 4'h1;
      end
      if ((op_reg == `SFR_DUAL_IO_READ_CMD && pos_reg == 4'h6) ||
          ((op_reg == `SFR_QUAD_IO_READ_CMD || quad_mode_reg) && op_reg != `SFR_DUAL_IO_READ_CMD && pos_reg == 4'h4) ||
          (op_reg != `SFR_DUAL_IO_READ_CMD && op_reg != `SFR_QUAD_IO_READ_CMD && !quad_mode_reg && pos_reg == 4'h7)) begin
        pos_reg  <= 4'h0;
        addr_reg <= addr_reg + 23'h000001;
      end
    end else if (state_reg == sfr_pkg::ST_DATA && oe_hold_reg != 4'h0) begin
      io_oe       <= oe_hold_reg;
      oe_hold_reg <= 4'h0;
    end else if (state_reg != sfr_pkg::ST_DATA) begin
      io_oe <= 4'h0;
    end
  end

  // Avalon slave: one wait cycle, then answer
  assign bus_acc = (avs_read | avs_write) & ~avs_waitrequest;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= 32'h00000000;
      if (avs_read) begin
        unique case (avs_address)
          `SFR_CTRL_IDX:     avs_readdata <= {27'h0, wip_reg, rst_pin_reg, dtr_reg, quad_en_reg, quad_mode_reg};
          `SFR_DUMMY_IDX:    avs_readdata <= {20'h0, dual_dummy_reg, quad_dummy_reg, fast_dummy_reg};
          `SFR_STATUS_IDX:   avs_readdata <= {26'h0, paused_reg, cont_reg, 1'b0, state_reg};
          `SFR_ADDR_IDX:     avs_readdata <= {9'h0, addr_reg};
          `SFR_MEM_PTR_IDX:  avs_readdata <= {24'h0, mem_ptr_reg};
          `SFR_MEM_DATA_IDX: avs_readdata <= {24'h0, mem[mem_ptr_reg]};
          default:           avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Settings steer the sequencer; reads never change them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quad_mode_reg  <= 1'b0;
      quad_en_reg    <= 1'b0;
      dtr_reg        <= 1'b0;
      rst_pin_reg    <= 1'b0;
      wip_reg        <= 1'b0;
      fast_dummy_reg <= `SFR_FAST_DUMMY_RST;
      quad_dummy_reg <= `SFR_QUAD_DUMMY_RST;
      dual_dummy_reg <= `SFR_DUAL_DUMMY_RST;
    end else if (bus_acc && avs_write && avs_address == `SFR_CTRL_IDX) begin
      quad_mode_reg <= avs_writedata[`SFR_CTRL_QUAD_MODE];
      quad_en_reg   <= avs_writedata[`SFR_CTRL_QUAD_EN];
      dtr_reg       <= avs_writedata[`SFR_CTRL_DTR];
      rst_pin_reg   <= avs_writedata[`SFR_CTRL_RST_PIN];
      wip_reg       <= avs_writedata[`SFR_CTRL_WIP];
    end else if (bus_acc && avs_write && avs_address == `SFR_DUMMY_IDX) begin
      fast_dummy_reg <= avs_writedata[3:0];
      quad_dummy_reg <= avs_writedata[7:4];
      dual_dummy_reg <= avs_writedata[11:8];
    end
  end

  // Array load window; pointer advances after each data access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ptr_reg <= 8'h00;
    end else if (bus_acc && avs_write && avs_address == `SFR_MEM_PTR_IDX) begin
      mem_ptr_reg <= avs_writedata[7:0];
    end else if (bus_acc && avs_address == `SFR_MEM_DATA_IDX) begin
      mem_ptr_reg <= mem_ptr_reg + 8'h01;
    end
  end

  // No reset on the array: contents are software loaded
  always_ff @(posedge clk) begin
    if (bus_acc && avs_write && avs_address == `SFR_MEM_DATA_IDX) begin
      mem[mem_ptr_reg] <= avs_writedata[7:0];
    end
  end

endmodule

// file: tb/serial_flash_read_path_tb.sv
`timescale 1ns/10ps
module serial_flash_read_path_tb;
  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, sck, cs_n, pause_n, rv;
  logic [3:0]  avs_address, io, io_out, io_oe, hd, he, ra;
  logic [31:0] avs_writedata, avs_readdata, ev, mv;
  logic [7:0]  mem [256];
  logic [7:0]  qc [4] = '{8'h0B, 8'hEB, 8'h4B, 8'h68};
  logic [31:0] eq [$];
  logic [31:0] mq [$];
  logic [8:0]  rb;
  int          fails, checks, seed;
  // Released lines show host data hd where he is set, and its inverse elsewhere
  assign io = (io_oe & io_out) | (~io_oe & ~(he ^ hd));
  sfr_top dut_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sck(sck), .cs_n(cs_n), .pause_n(pause_n),
    .io_in(io), .io_out(io_out), .io_oe(io_oe));
  sfr_host h_u (.clk(clk), .io(io), .sck(sck), .cs_n(cs_n), .pause_n(pause_n), .hd(hd), .he(he));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rv || (avs_read && avs_waitrequest === 1'b0)) begin
      ev = eq.pop_front();
      mv = mq.pop_front();
      chk((rv ? {23'h0, rb} : avs_readdata) & mv, ev & mv);
    end
  end
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdr(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    av(1'b0, a, 32'h0);
  endtask
  task automatic tx(input logic [23:0] v, input int n, input int l);
    logic [3:0] q;
    repeat (n / l) begin
      h_u.cyc(v[23 -: 4] >> (4 - l), 4'hF >> (4 - l), q);
      v = v << l;
    end
  endtask
  task automatic dm(input int n);
    logic [3:0] q;
    repeat (n) h_u.cyc(4'($random(seed)), 4'h0, q);
  endtask
  // Noise on io0 in single-line reads must be ignored
  task automatic rx(input int l, input logic [31:0] e, input logic [31:0] m);
    logic [3:0] q;
    logic [7:0] b;
    logic       o;
    o = 1'b0;
    b = 8'h00;
    repeat (8 / l) begin
      h_u.cyc(4'($random(seed)), {3'h0, l == 1}, q);
      b = (b << l) | ((l == 1) ? q[1] : q & (4'hF >> (4 - l)));
      o = o | (|io_oe);
    end
    eq.push_back(e);
    mq.push_back(m);
    rb <= {o, b};
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] op, input int l, input logic [23:0] a, input int dn, input int nb,
                     input logic ok);
    h_u.fr(1'b0);
    tx({op, 16'h0}, 8, l);
    tx(a, 24, l);
    dm(dn);
    for (int k = 0; k < nb; k++) rx(l, {23'h0, ok, mem[8'(a + k)]}, ok ? 32'h1FF : 32'h100);
    h_u.fr(1'b1);
  endtask
  task automatic rdd(input logic c, input logic [23:0] a, input logic [3:0] md);
    h_u.fr(1'b0);
    if (c) tx({8'hBB, 16'h0}, 8, 1);
    tx(a, 24, 2);
    tx({md, 20'h0}, 4, 2);
    dm(2);
    rx(2, {24'h1, mem[a[7:0]]}, 32'h1FF);
    h_u.fr(1'b1);
  endtask
  initial begin
    {arst_n, avs_read, avs_write, rv, avs_address, avs_writedata, rb} = '0;
    seed = 32'h69FC;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Unmapped words: writes vanish, reads give zero
    for (int i = 0; i < 6; i++) begin
      ra = 4'($random(seed)) | 4'h8;
      if ($random(seed) & 1) av(1'b1, ra, $random(seed));
      else rdr(ra, 32'h0, 32'hFFFFFFFF);
    end
    rdr(4'h1, 32'h468, 32'hFFF);
    rdr(4'h0, 32'h0, 32'h1F);
    rdr(4'hF, 32'h0, 32'hFFFFFFFF);
    av(1'b1, 4'h4, 32'h0);
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      av(1'b1, 4'h5, {24'h0, mem[i]});
    end
    rdc(8'h03, 1, 24'hFFFFFE, 0, 3, 1'b1);
    for (int i = 0; i < 2; i++) begin
      av(1'b1, 4'h1, i ? 32'h463 : 32'h468);
      rdc(8'h0B, 1, 24'h00A5C3, i ? 3 : 8, 2, 1'b1);
    end
    av(1'b1, 4'h0, 32'h1);
    foreach (qc[i]) rdc(qc[i], 4, 24'h3C0011 + 24'(i), 6, 2, 1'b1);
    rdr(4'h0, 32'h1, 32'h1F);
    av(1'b1, 4'h0, 32'h10);
    rdc(8'h03, 1, 24'h000010, 0, 1, 1'b0);
    rdr(4'h0, 32'h10, 32'h1F);
    av(1'b1, 4'h0, 32'h0);
    rdd(1'b1, 24'h000040, 4'hA);
    rdr(4'h2, 32'h10, 32'h10);
    rdd(1'b0, 24'h000050, 4'h5);
    rdr(4'h2, 32'h0, 32'h10);
    rdd(1'b1, 24'h000060, 4'h0);
    h_u.fr(1'b0);
    tx(24'h030000, 8, 1);
    tx(24'h000080, 24, 1);
    rx(1, {24'h1, mem[8'h80]}, 32'h1FF);
    h_u.pz(1'b0);
    dm(2);
    chk({28'h0, io_oe}, 32'h0);
    rdr(4'h2, 32'h20, 32'h20);
    h_u.pz(1'b1);
    rx(1, {24'h1, mem[8'h81]}, 32'h1FF);
    h_u.fr(1'b1);
    // Quad enable blocks the pause, data keeps flowing
    av(1'b1, 4'h0, 32'h2);
    rdr(4'h0, 32'h2, 32'h1F);
    h_u.fr(1'b0);
    tx(24'h030000, 8, 1);
    tx(24'h000090, 24, 1);
    h_u.pz(1'b0);
    rdr(4'h2, 32'h0, 32'h20);
    rx(1, {24'h1, mem[8'h90]}, 32'h1FF);
    h_u.pz(1'b1);
    h_u.fr(1'b1);
    summarize();
  end
  // Several times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
bind sfr_top sfr_props p_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sck(sck), .cs_n(cs_n), .pause_n(pause_n), .io_in(io_in),
  .io_out(io_out), .io_oe(io_oe));

// file: tb/sfr_host.sv
`timescale 1ns/10ps
module sfr_host (
  // Clock
  input  wire logic       clk,
  // Link
  input  wire logic [3:0] io,
  output logic            sck,
  output logic            cs_n,
  output logic            pause_n,
  output logic [3:0]      hd,
  output logic [3:0]      he
);
  // Clock stands low between frames
  initial {sck, cs_n, pause_n, hd, he} = 11'h300;
  // Sample just before the fall, when the data is oldest
  task automatic cyc(input logic [3:0] d, input logic [3:0] e, output logic [3:0] q);
    hd <= d;
    he <= e;
    repeat (4) @(posedge clk);
    sck <= 1'b1;
    repeat (4) @(posedge clk);
    q = io;
    sck <= 1'b0;
  endtask
  task automatic fr(input logic v);
    cs_n <= v;
    repeat (8) @(posedge clk);
  endtask
  // Called only while sck is low
  task automatic pz(input logic v);
    pause_n <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: tb/sfr_properties.sv
`timescale 1ns/10ps
module sfr_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Avalon-MM slave
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Serial link
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        pause_n,
  input wire logic [3:0]  io_in,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe
);
  logic [6:0] low_reg;
  // Cycles of continuous select, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_reg <= 7'h00;
    end else if (cs_n) begin
      low_reg <= 7'h00;
    end else if (low_reg != 7'h7F) begin
      low_reg <= low_reg + 7'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  property p_cause;
    $fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write);
  endproperty
  property p_rd_hold;
    $changed(avs_readdata) |-> !avs_waitrequest;
  endproperty
  property p_cs_off;
    cs_n [*6] |-> io_oe == 4'h0;
  endproperty
  property p_out_fall;
    !cs_n && io_oe != 4'h0 && $changed(io_out) |-> !$past(sck, 2);
  endproperty
  property p_oe_fall;
    $rose(io_oe != 4'h0) |-> !$past(sck, 2);
  endproperty
  // Shortest frame is 7 link clocks of 8 cycles
  property p_oe_late;
    $rose(io_oe != 4'h0) |-> low_reg >= 7'h38;
  endproperty
  property p_oe_shape;
    io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hF;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no single wait cycle answer");
  a_cause: assert property (p_cause)
    else $error("answer without request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved outside answer");
  a_cs_off: assert property (p_cs_off)
    else $error("driving while deselected");
  a_out_fall: assert property (p_out_fall)
    else $error("output changed off falling edge");
  a_oe_fall: assert property (p_oe_fall)
    else $error("drive started off falling edge");
  a_oe_late: assert property (p_oe_late)
    else $error("drive started too early in frame");
  a_oe_shape: assert property (p_oe_shape)
    else $error("bad enable pattern");
endmodule
